// ---- common/led_sink_pkg.sv ----
// Purpose: shared constants for the led sink control block
// Assumes: 100 MHz aclk, serial link sampled by aclk
// Notes: register map and control-latch field layout live here
package led_sink_pkg;
  // ****************************************************
  // serial frame layout
  // ****************************************************
  localparam int SHIFT_W = 49;
  localparam int CH_N = 48;
  localparam int SEL_BIT = 48;           // data select bit
  localparam int CMD_HI = 47;
  localparam int CMD_LO = 40;
  localparam logic [7:0] WRITE_CMD = 8'h96;
  localparam int BC_R_LO = 3;            // 7-bit brightness fields
  localparam int BC_G_LO = 10;
  localparam int BC_B_LO = 17;
  localparam int MC_LO = 24;             // 3-bit max current code
  localparam int OPEN_THR_LO = 27;       // 3 bits
  localparam int SHORT_THR_LO = 30;      // 2 bits
  localparam int STAT_SEL_LO = 32;       // 2 bits
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;
  // ****************************************************
  // current computation, hundredths of a milliamp
  // ****************************************************
  localparam int BC_FULL = 127;
  localparam logic [13:0] CUR_BASE = 14'h02fa;   // 0.06 * 127 * 100
  localparam logic [13:0] CUR_SLOPE = 14'h005e;  // 0.94 * 100
  localparam logic [22:0] CUR_DIV = 23'h0004f6;  // 127 * 10
  typedef logic [8:0] peak_tab_t [8];            // tenths of mA
  localparam peak_tab_t PEAK_RG = '{9'h01d, 9'h02c, 9'h03a, 9'h057,
                                   9'h074, 9'h0ae, 9'h0e8, 9'h15d};
  localparam peak_tab_t PEAK_B = '{9'h014, 9'h01f, 9'h029, 9'h03d,
                                  9'h051, 9'h07a, 9'h0a3, 9'h0f4};
  // ****************************************************
  // register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] REG_STEP = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_ONOFF_LO = 8'h08;
  localparam logic [7:0] REG_ONOFF_HI = 8'h0c;
  localparam logic [7:0] REG_STAT_LO = 8'h10;
  localparam logic [7:0] REG_STAT_HI = 8'h14;
  localparam logic [15:0] STEP_RESET = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : led_sink_pkg

// ---- src/sync_stage.sv ----
// Purpose: two flip-flop synchroniser for a bus of independent levels
// Assumes: each bit is a slow level, no bus coherence needed
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module sync_stage #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  // two stages, nothing reads meta_r but hold_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= din;
      hold_r <= meta_r;
    end
  end

  assign dout = hold_r;
endmodule : sync_stage

// ---- src/stagger_seq.sv ----
// Purpose: staggered channel switching, one channel per step
// Assumes: step_cycles is at least one
// Notes: a target change mid-walk restarts the walk from the start
`timescale 1ns/1ps
module stagger_seq #(
  parameter int CH = 48
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CH-1:0] target,
  input wire logic [15:0] step_cycles,
  output logic [CH-1:0] on_r
);
  logic [CH-1:0] snap_r;
  logic busy_r;
  logic [1:0] col_r;
  logic [3:0] pos_r;
  logic [15:0] cnt_r;
  logic [3:0] pair_n;
  logic [5:0] ch_idx;
  logic last_step;

  // order: n = 0, 15, 1, 14 ... 8, red green blue each
  assign pair_n = pos_r[0] ? 4'(4'hf - {1'b0, pos_r[3:1]})
                           : {1'b0, pos_r[3:1]};
  assign ch_idx = 6'({2'b00, pair_n} * 6'h3 + {4'h0, col_r});
  assign last_step = (pos_r == 4'hf) && (col_r == 2'h2);

  // same walk and same step delay for turn-on and turn-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_r <= '0;
      on_r <= '0;
      busy_r <= 1'b0;
      col_r <= '0;
      pos_r <= '0;
      cnt_r <= '0;
    end else if (target != snap_r) begin
      snap_r <= target;
      busy_r <= 1'b1;
      col_r <= '0;
      pos_r <= '0;
      cnt_r <= '0;
    end else if (busy_r && cnt_r != 16'h0) begin
      cnt_r <= 16'(cnt_r - 16'h1);      // RQ23
    end else if (busy_r) begin
      on_r[ch_idx] <= snap_r[ch_idx];   // RQ14 RQ15
      cnt_r <= 16'(step_cycles - 16'h1);
      busy_r <= !last_step;
      col_r <= (col_r == 2'h2) ? 2'h0 : 2'(col_r + 2'h1);
      if (col_r == 2'h2) begin
        pos_r <= 4'(pos_r + 4'h1);
      end
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  a_one_per_step: assert property (@(posedge aclk) disable iff (!aresetn)
    $countones(on_r ^ $past(on_r)) <= 1) // RQ15
    else $error("more than one channel switched in a cycle");
  c_walk_done: cover property (@(posedge aclk) disable iff (!aresetn)
    busy_r && last_step && cnt_r == 16'h0);
endmodule : stagger_seq

// ---- src/led_sink_ctrl.sv ----
// Purpose: control logic of a 48-channel constant-current sink driver
// Assumes: link pins are slow against aclk and pass two flip-flops
// Notes: analog comparators sit outside; their results come in as
//        open_cmp / short_cmp, and currents leave as codes
// Behaviour
// (RQ1) channel current is peak times 0.06 plus 0.94 times code/127
// (RQ2) seven-bit brightness code per colour group, sixteen channels each
// (RQ3) on-off write copies shift register, then loads selected status
// (RQ4) brightness and function write loads no status word
// (RQ5) one status load until new data are shifted in
// (RQ6) controller waits setup after power save, then raises output_gate
// (RQ7) open flag set when sink node at or below open threshold
// (RQ8) short flag set when sink node above short threshold
// (RQ9) flags forced to zero for channels off in on-off latch
// (RQ10) selector 01b captures open flags on output_gate rise
// (RQ11) selector 10b captures short flags on output_gate rise
// (RQ12) captured status is read out through shift register
// (RQ13) controller ignores flags within 1 us of turn-on
// (RQ14) channels switch staggered in pair order 0, 15, 1 ... 8
// (RQ15) stagger applies to turn-off as well as turn-on
// (RQ16) max current code updates only after two equal writes
// (RQ17) max current code clears to zero at reset
// (RQ18) max current code selects group peak current from table
// (RQ19) 49-bit shift register takes serial_in at lsb, msb out
// (RQ20) top bit zero: load_strobe copies low 48 bits to on-off
// (RQ21) selectors 00b and 11b load no status word
// (RQ22) output_gate high forces all off, latch kept
// (RQ23) per-step stagger delay is one adjustable equal delay
`timescale 1ns/1ps
module led_sink_ctrl
  import led_sink_pkg::*;
#(
  parameter int CH = led_sink_pkg::CH_N
) (
  input wire logic aclk,
  input wire logic aresetn,
  // serial link pins
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic output_gate,
  output logic serial_out,
  // comparator results per channel
  input wire logic [CH-1:0] open_cmp,
  input wire logic [CH-1:0] short_cmp,
  // analog controls
  output logic [CH-1:0] sink_channel,
  output logic [2:0] max_current_code,
  output logic [2:0] open_threshold_sel,
  output logic [1:0] short_threshold_sel,
  output logic [11:0] current_red,
  output logic [11:0] current_green,
  output logic [11:0] current_blue,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************************
  // pin synchronisers and edge detection
  // ****************************************************
  logic [3:0] pins_s;
  logic [2*CH-1:0] cmp_s;
  logic [2:0] edge_d_r;
  logic sclk_rise, lat_rise, gate_rise, sin_s, gate_s;
  sync_stage #(.W(4)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({shift_clock, serial_in, load_strobe, output_gate}),
    .dout(pins_s)
  );
  sync_stage #(.W(2 * CH)) u_cmp_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({short_cmp, open_cmp}),
    .dout(cmp_s)
  );
  // edges are taken from synchronised copies only
  assign sin_s = pins_s[2];
  assign gate_s = pins_s[0];
  assign sclk_rise = pins_s[3] && !edge_d_r[2];
  assign lat_rise = pins_s[1] && !edge_d_r[1];
  assign gate_rise = pins_s[0] && !edge_d_r[0];
  // serial_in needs no delayed copy, only the three strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_d_r <= '0;
    end else begin
      edge_d_r <= {pins_s[3], pins_s[1:0]};
    end
  end
  // ****************************************************
  // shift register and latches
  // ****************************************************
  logic [SHIFT_W-1:0] shift_r;
  logic [CH-1:0] onoff_r, holder_r, open_flag, short_flag;
  logic sid_loaded_r, mc_pend_ok_r;
  logic [2:0] mc_r, mc_pend_r, mc_field;
  logic [6:0] bc_r_r, bc_g_r, bc_b_r;
  logic [2:0] open_thr_r;
  logic [1:0] short_thr_r, sel_r;
  logic onoff_wr, fc_wr, sel_ok, mc_take;
  // comparators arrive already at/below and above thresholds
  assign open_flag = cmp_s[CH-1:0] & onoff_r;     // RQ7 RQ9
  assign short_flag = cmp_s[2*CH-1:CH] & onoff_r; // RQ8 RQ9
  assign onoff_wr = lat_rise && !shift_r[SEL_BIT];             // RQ20
  assign fc_wr = lat_rise && shift_r[SEL_BIT]
    && shift_r[CMD_HI:CMD_LO] == WRITE_CMD;
  assign sel_ok = (sel_r == SEL_OPEN) || (sel_r == SEL_SHORT); // RQ21
  assign mc_field = shift_r[MC_LO +: 3];
  assign mc_take = fc_wr && mc_pend_ok_r && (mc_field == mc_pend_r); // RQ16
  // load has priority over a coincident shift edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= '0;
      sid_loaded_r <= 1'b0;
    end else if (onoff_wr && sel_ok && !sid_loaded_r) begin
      shift_r[CH-1:0] <= holder_r;                 // RQ3 RQ12
      sid_loaded_r <= 1'b1;                        // RQ5
    end else if (sclk_rise && !lat_rise) begin
      shift_r <= {shift_r[SHIFT_W-2:0], sin_s};    // RQ19
      sid_loaded_r <= 1'b0;                        // RQ5
    end
  end
  // on-off latch and status holder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      onoff_r <= '0;
      holder_r <= '0;
    end else begin
      if (onoff_wr) begin
        onoff_r <= shift_r[CH-1:0];                // RQ3 RQ20
      end
      if (gate_rise && sel_r == SEL_OPEN) begin
        holder_r <= open_flag;                     // RQ10
      end else if (gate_rise && sel_r == SEL_SHORT) begin
        holder_r <= short_flag;                    // RQ11
      end
    end
  end
  // brightness, function and max current latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bc_r_r <= '0;
      bc_g_r <= '0;
      bc_b_r <= '0;
      open_thr_r <= '0;
      short_thr_r <= '0;
      sel_r <= '0;
      mc_r <= '0;                                  // RQ17
      mc_pend_r <= '0;
      mc_pend_ok_r <= 1'b0;
    end else if (fc_wr) begin                      // RQ4
      bc_r_r <= shift_r[BC_R_LO +: 7];             // RQ2
      bc_g_r <= shift_r[BC_G_LO +: 7];             // RQ2
      bc_b_r <= shift_r[BC_B_LO +: 7];             // RQ2
      open_thr_r <= shift_r[OPEN_THR_LO +: 3];
      short_thr_r <= shift_r[SHORT_THR_LO +: 2];
      sel_r <= shift_r[STAT_SEL_LO +: 2];
      mc_pend_r <= mc_field;
      mc_pend_ok_r <= 1'b1;
      if (mc_take) begin
        mc_r <= mc_field;                          // RQ16
      end
    end
  end

  // ****************************************************
  // group currents and staggered switching
  // ****************************************************
  function automatic logic [11:0] cur_calc(input logic [8:0] peak,
                                           input logic [6:0] bc);
    logic [13:0] ratio;
    logic [22:0] prod;
    ratio = 14'(CUR_BASE + CUR_SLOPE * {7'h00, bc});
    prod = 23'({14'h0, peak} * {9'h0, ratio});
    return 12'(prod / CUR_DIV);                    // RQ1
  endfunction : cur_calc
  logic [15:0] step_r;
  logic [CH-1:0] gated_target;
  assign gated_target = gate_s ? '0 : onoff_r;     // RQ22
  stagger_seq #(.CH(CH)) u_stagger (
    .aclk(aclk),
    .aresetn(aresetn),
    .target(gated_target),
    .step_cycles(step_r),
    .on_r(sink_channel)
  );
  // output registers for analog controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_red <= '0;
      current_green <= '0;
      current_blue <= '0;
    end else begin
      current_red <= cur_calc(PEAK_RG[mc_r], bc_r_r);   // RQ18
      current_green <= cur_calc(PEAK_RG[mc_r], bc_g_r); // RQ18
      current_blue <= cur_calc(PEAK_B[mc_r], bc_b_r);   // RQ18
    end
  end

  assign serial_out = shift_r[SEL_BIT];            // RQ19
  assign max_current_code = mc_r;
  assign open_threshold_sel = open_thr_r;
  assign short_threshold_sel = short_thr_r;
  // ****************************************************
  // axi4-lite slave
  // ****************************************************
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r, w_have_r;
  logic [31:0] rd_word;
  logic rd_hit, wr_step;
  assign wr_step = awaddr_r == REG_STEP;
  assign rd_hit = s_axi_araddr inside {REG_STEP, REG_CONFIG,
    REG_ONOFF_LO, REG_ONOFF_HI, REG_STAT_LO, REG_STAT_HI};
  assign rd_word =
    (s_axi_araddr == REG_STEP) ? {16'h0, step_r} :
    (s_axi_araddr == REG_CONFIG) ? {1'b0, sel_r, short_thr_r,
      open_thr_r, mc_r, bc_b_r, bc_g_r, bc_r_r} :
    (s_axi_araddr == REG_ONOFF_LO) ? onoff_r[31:0] :
    (s_axi_araddr == REG_ONOFF_HI) ? {16'h0, onoff_r[CH-1:32]} :
    (s_axi_araddr == REG_STAT_LO) ? holder_r[31:0] :
    (s_axi_araddr == REG_STAT_HI) ? {16'h0, holder_r[CH-1:32]} :
    32'h0;

  // address and data taken in either order, answer one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      step_r <= STEP_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_step ? RESP_OKAY : RESP_SLVERR;
        if (wr_step && wstrb_r[0]) step_r[7:0] <= wdata_r[7:0];
        if (wr_step && wstrb_r[1]) step_r[15:8] <= wdata_r[15:8];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // read channel, data registered with the acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_shift_moves_in: assert property ( // RQ19
    sclk_rise && !lat_rise |=> shift_r == {$past(shift_r[SHIFT_W-2:0]),
      $past(sin_s)})
    else $error("shift register did not shift");
  a_onoff_copy: assert property ( // RQ20
    onoff_wr |=> onoff_r == $past(shift_r[CH-1:0]))
    else $error("on-off latch not written");
  a_status_load: assert property ( // RQ3
    onoff_wr && sel_ok && !sid_loaded_r |=>
      shift_r[CH-1:0] == $past(holder_r) && sid_loaded_r)
    else $error("status word not loaded");
  a_no_fc_load: assert property ( // RQ4
    lat_rise && shift_r[SEL_BIT] |=> shift_r == $past(shift_r))
    else $error("status loaded on control write");
  a_single_load: assert property ( // RQ5
    lat_rise && sid_loaded_r |=> $stable(shift_r))
    else $error("second status load without shifting");
  a_sel_none: assert property ( // RQ21
    onoff_wr && !sel_ok |=> $stable(shift_r))
    else $error("status loaded with idle selector");
  a_open_capture: assert property ( // RQ10
    gate_rise && sel_r == SEL_OPEN |=>
      holder_r == $past(cmp_s[CH-1:0] & onoff_r))
    else $error("open flags not captured");
  a_short_capture: assert property ( // RQ11
    gate_rise && sel_r == SEL_SHORT |=>
      holder_r == $past(cmp_s[2*CH-1:CH] & onoff_r))
    else $error("short flags not captured");
  a_mc_double: assert property ( // RQ16
    fc_wr && !mc_take |=> $stable(mc_r))
    else $error("max current changed on single write");
  a_gate_off: assert property ( // RQ22
    gate_s && $past(gate_s) && !onoff_wr |=> $stable(onoff_r)
      && (sink_channel & ~$past(sink_channel)) == '0)
    else $error("gate high switched a channel on");
  c_onoff_load: cover property (onoff_wr && sel_ok && !sid_loaded_r);
  c_mc_update: cover property (mc_take ##1 mc_r != $past(mc_r));
  c_open_capture: cover property (gate_rise && sel_r == SEL_OPEN);
endmodule : led_sink_ctrl

// ---- testbench/link_host_model.sv ----
// Purpose: display controller model on the serial link pins
// Assumes: link clock of 16 aclk periods (160 ns), low between frames
// Notes: serial_in idles at the inverse of its last bit, never parked
`timescale 1ns/1ps
module link_host_model (
  input wire logic aclk,
  input wire logic serial_out,
  output logic shift_clock,
  output logic serial_in,
  output logic load_strobe,
  output logic output_gate
);
  // ****************************************************
  // pin drivers
  // ****************************************************
  // gate starts high so nothing lights before setup
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b1;
    load_strobe = 1'b0;
    output_gate = 1'b1;
  end
  // latch pulse kept well away from any shift edge
  task automatic pulse();
    repeat (8) @(posedge aclk);
    load_strobe <= 1'b1;
    repeat (8) @(posedge aclk);
    load_strobe <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse
  // msb first; q keeps what serial_out showed before each rise
  task automatic frame(input logic [48:0] d, output logic [48:0] q);
    for (int i = 48; i >= 0; i--) begin
      serial_in <= d[i];
      repeat (8) @(posedge aclk);
      q[i] = serial_out;
      shift_clock <= 1'b1;
      repeat (8) @(posedge aclk);
      shift_clock <= 1'b0;
    end
    serial_in <= ~d[0];  // released line shows no stale bit
    pulse();
  endtask : frame
  // rise only after a long lit time, flags need to settle
  task automatic gate(input logic v);
    if (v) repeat (300) @(posedge aclk);
    output_gate <= v;
  endtask : gate
endmodule : link_host_model

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the led sink control block
// Assumes: seed 82, link driven by the host model at 160 ns
// Notes: expectations come from bench functions and package constants
`timescale 1ns/1ps
module tb;
  import led_sink_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic shift_clock, serial_in, load_strobe, output_gate, serial_out;
  logic [47:0] open_cmp = '0;
  logic [47:0] short_cmp = '0;
  logic [47:0] sink_channel, lat, hold_old, v;
  logic [47:0] hold = '0;
  logic [2:0] max_current_code, open_threshold_sel, m, mc_prev;
  logic [2:0] mc_e = '0;
  logic [1:0] short_threshold_sel, s_axi_bresp, s_axi_rresp;
  logic [11:0] current_red, current_green, current_blue;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata, d, d2;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic armed = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 82;
  logic [15:0] st;
  logic [48:0] f, fo, fg, q;
  logic [6:0] r, g, b;
  logic [4:0] th;
  logic [1:0] sels [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
  always #5 aclk = ~aclk;
  led_sink_ctrl u_dut (.aclk, .aresetn, .shift_clock, .serial_in,
    .load_strobe, .output_gate, .serial_out, .open_cmp, .short_cmp,
    .sink_channel, .max_current_code, .open_threshold_sel,
    .short_threshold_sel, .current_red, .current_green, .current_blue,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  link_host_model u_link (.aclk, .serial_out, .shift_clock, .serial_in,
    .load_strobe, .output_gate);
  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [11:0] cur(input logic [8:0] pk,
                                      input logic [6:0] bc);
    return 12'((32'(pk) * (32'd762 + 32'd94 * 32'(bc))) / 32'd1270);
  endfunction : cur
  // pairs n and 15-n, red green blue each
  function automatic int seq_bit(input int k);
    int p;
    p = k / 3;
    return 3 * ((p % 2) ? 15 - p / 2 : p / 2) + k % 3;
  endfunction : seq_bit
  function automatic logic [47:0] rnd48();
    return 48'({$random(seed), $random(seed)});
  endfunction : rnd48
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic guard(input logic ok);
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report();
    end
  endtask : guard
  // both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                    input logic [1:0] er);
    int n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd) && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin @(posedge aclk); n++; end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    guard(n < 50);
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dq,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    dq = s_axi_rdata;
    guard(n < 50);
    chk(s_axi_rresp, er);
  endtask : rd
  task automatic rd48(input logic [7:0] a, output logic [47:0] w);
    rd(a, d, RESP_OKAY);
    rd(8'(a + 8'h4), d2, RESP_OKAY);
    w = {d2[15:0], d};
  endtask : rd48
  // follows one full walk, every channel changing
  task automatic walk(input logic on);
    logic [47:0] e;
    int n;
    e = on ? '0 : '1;
    for (int k = 0; k < 48; k++) begin
      n = 0;
      while (sink_channel === e && n < 400) begin
        @(posedge aclk);
        n++;
      end
      guard(n < 400);
      if (k > 0) chk(n, st);
      e[seq_bit(k)] = on;
      chk(sink_channel, e);
    end
  endtask : walk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // ****************************************************
  // sequence
  // ****************************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk(max_current_code, 3'h0);
    rd(REG_STEP, d, RESP_OKAY);
    chk(d, 32'(STEP_RESET));
    rd(8'h20, d, RESP_SLVERR);
    chk(d, 32'h0);
    wr(REG_CONFIG, 32'hffffffff, RESP_SLVERR);
    st = 16'(2 + {$random(seed)} % 4);
    s_axi_wstrb <= 4'hd;
    wr(REG_STEP, {24'hffffff, st[7:0]}, RESP_OKAY);  // lane 1 masked
    s_axi_wstrb <= 4'hf;
    rd(REG_STEP, d, RESP_OKAY);
    chk(d, {16'h0, st});
    $display("test registers done");
    u_link.frame({1'b0, 48'hffffffffffff}, q);
    lat = '1;
    rd48(REG_ONOFF_LO, v);
    chk(v, lat);
    chk(sink_channel, 48'h0);
    u_link.gate(1'b0);
    walk(1'b1);
    u_link.gate(1'b1);
    walk(1'b0);
    $display("test stagger done");
    for (int i = 0; i < 4; i++) begin
      m = 3'($random(seed));
      r = 7'($random(seed));
      g = 7'($random(seed));
      b = 7'($random(seed));
      th = 5'($random(seed));
      f = '0;
      f[SEL_BIT] = 1'b1;
      f[CMD_HI:CMD_LO] = WRITE_CMD;
      f[BC_R_LO +: 7] = r;
      f[BC_G_LO +: 7] = g;
      f[BC_B_LO +: 7] = b;
      f[MC_LO +: 3] = m;
      f[OPEN_THR_LO +: 5] = th;
      f[STAT_SEL_LO +: 2] = sels[i];
      u_link.frame(f, q);
      if (armed && m == mc_prev) mc_e = m;
      armed = 1'b1;
      mc_prev = m;
      chk(max_current_code, mc_e);
      u_link.frame(f, q);
      chk(q, f);
      chk(max_current_code, m);
      chk(current_red, cur(PEAK_RG[m], r));
      chk(current_green, cur(PEAK_RG[m], g));
      chk(current_blue, cur(PEAK_B[m], b));
      chk({short_threshold_sel, open_threshold_sel}, th);
      rd(REG_CONFIG, d, RESP_OKAY);
      chk(d, {1'b0, sels[i], th, m, b, g, r});
      mc_e = m;
      open_cmp <= rnd48();
      short_cmp <= rnd48();
      u_link.gate(1'b0);
      u_link.gate(1'b1);
      repeat (8) @(posedge aclk);
      if (sels[i] == SEL_OPEN) hold = open_cmp & lat;
      if (sels[i] == SEL_SHORT) hold = short_cmp & lat;
      rd48(REG_STAT_LO, v);
      if (^sels[i]) chk(v, hold);
      fo = {1'b0, rnd48()};
      fg = {1'b0, rnd48()};
      u_link.frame(fo, q);
      u_link.frame(fg, q);
      chk(q, (^sels[i]) ? {1'b0, hold} : fo);
      lat = fg[47:0];
      rd48(REG_ONOFF_LO, v);
      chk(v, lat);
      $display("test select %0d done", sels[i]);
    end
    // holder changes, but a bare latch pulse must not reload it
    hold_old = hold;
    open_cmp <= rnd48();
    u_link.gate(1'b0);
    u_link.gate(1'b1);
    repeat (8) @(posedge aclk);
    u_link.pulse();
    u_link.frame(fo, q);
    chk(q, {1'b0, hold_old});
    $display("test reload guard done");
    final_report();
  end
endmodule : tb
